/* rtl/thermal_pkg.sv */
// shared constants, types and scaling of the thermal replica
`default_nettype none
package thermal_pkg;
  localparam int CUR_W = 12;                  // phase magnitude, lsb = 0.01 x rated
  localparam int SET_W = 9;                   // full-load setting, lsb = 0.01 x rated
  localparam int PCT_W = 7;
  localparam int TAU_W = 8;                   // time constants in minutes
  localparam int TH_W  = 40;                  // thermal state, 1.0 = 2**FRAC
  localparam int FRAC  = 16;
  localparam int OUT_W = 32;
  localparam int NUM_W = 52;                  // divider numerator width
  localparam int DEN_W = 32;
  localparam logic [TH_W-1:0] THETA_ONE   = 40'h00_0001_0000;
  localparam logic [8:0]      K_SQ_NUM    = 9'h190;   // k*k = 441/400, k = 1.05
  localparam logic [8:0]      K_SQ_DEN    = 9'h1B9;
  localparam logic [16:0]     W_WINDING   = 17'h06666; // 0.4 in Q16
  localparam logic [16:0]     W_OIL       = 17'h0999A; // 0.6 in Q16
  localparam logic [SET_W-1:0] FLS_MIN    = 9'h008;    // 0.08 x rated
  localparam logic [SET_W-1:0] FLS_MAX    = 9'h140;    // 3.20 x rated
  localparam logic [SET_W-1:0] ALARM_MIN  = 9'h032;    // 50 percent
  localparam logic [SET_W-1:0] ALARM_MAX  = 9'h064;    // 100 percent
  localparam logic [SET_W-1:0] TAU_MIN    = 9'h001;    // 1 minute
  localparam logic [SET_W-1:0] TAU_MAX    = 9'h0C8;    // 200 minutes
  localparam logic [6:0]      PCT_SCALE   = 7'h64;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SAMPLE_MS     = 10;
  localparam int SAMPLE_CYC    = SAMPLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STEPS_PER_MIN = 60000 / SAMPLE_MS;
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_DUAL   = 2'h2
  } mode_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_TGT  = 3'b001,
    S_WIND = 3'b011,
    S_OIL  = 3'b010,
    S_UPD  = 3'b110
  } seq_t;
endpackage
`default_nettype wire

/* rtl/div_if.sv */
// request and answer between the sequencer and the serial divider
`default_nettype none
interface div_if #(parameter int NW = 52, parameter int DW = 32);
  logic          start;
  logic [NW-1:0] num;
  logic [DW-1:0] den;
  logic          busy;
  logic          done;
  logic [NW-1:0] quo;
  modport req (output start, num, den, input busy, done, quo);
  modport srv (input start, num, den, output busy, done, quo);
endinterface
`default_nettype wire

/* rtl/thermal_div.sv */
// restoring serial divider, one quotient bit per clock
`default_nettype none
module thermal_div #(
  parameter int NW = 52,
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // divide requests
  div_if.srv        d
);
  localparam int CW = $clog2(NW + 1);
  logic [NW-1:0] q_r, q_nxt;
  logic [DW:0]   rem_r, rem_nxt, rem_sh;
  logic [DW-1:0] den_r, den_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          busy_r, busy_nxt, done_r, done_nxt, ge;

  always_comb begin
    rem_sh   = {rem_r[DW-1:0], q_r[NW-1]};
    ge       = rem_sh >= {1'b0, den_r};
    q_nxt    = q_r;
    rem_nxt  = rem_r;
    den_nxt  = den_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (d.start && !busy_r) begin
      q_nxt    = d.num;
      rem_nxt  = '0;
      den_nxt  = d.den;
      cnt_nxt  = CW'(NW);
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      rem_nxt = ge ? rem_sh - {1'b0, den_r} : rem_sh;
      q_nxt   = {q_r[NW-2:0], ge};
      cnt_nxt = cnt_r - 1'b1;
      if (cnt_r == 1) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r    <= '0;
      rem_r  <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      q_r    <= q_nxt;
      rem_r  <= rem_nxt;
      den_r  <= den_nxt;
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign d.busy = busy_r;
  assign d.done = done_r;
  assign d.quo  = q_r;

  div_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_13
    d.start && !busy_r |-> ##[1:60] done_r)
    else $error("divider did not finish in time");
endmodule
`default_nettype wire

/* rtl/thermal_overload.sv */
// current based thermal replica with alarm and trip stages
// Function
// RULE_01 - model input is the largest of the three phase magnitudes, each update
// RULE_02 - single mode: target is I squared over (k times full load) squared
// RULE_03 - k is fixed at 1.05
// RULE_04 - trip once the thermal state reaches 100 percent
// RULE_05 - state carries over, so preload shortens the time to trip
// RULE_06 - dual mode: two exponential parts weighted 0.4 and 0.6
// RULE_07 - first constant models windings, second models the oil
// RULE_08 - current only, no ambient temperature correction
// RULE_09 - settings clamped to their documented ranges and steps
// RULE_10 - present thermal state always available on an output
// RULE_11 - logic input or menu command clears the thermal state to zero
// RULE_12 - alarm output at the configured percentage, separate from trip
// RULE_13 - fixed-period discrete recurrence; outputs low when disabled
`default_nettype none
module thermal_overload
  import thermal_pkg::*;
#(
  parameter int SAMPLE_CYCLES = thermal_pkg::SAMPLE_CYC
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  // phase current magnitudes
  input  wire logic [thermal_pkg::CUR_W-1:0] phase_a,
  input  wire logic [thermal_pkg::CUR_W-1:0] phase_b,
  input  wire logic [thermal_pkg::CUR_W-1:0] phase_c,
  // settings
  input  wire thermal_pkg::mode_t           char_mode,
  input  wire logic [thermal_pkg::SET_W-1:0] full_load_setting,
  input  wire logic [thermal_pkg::PCT_W-1:0] alarm_pct,
  input  wire logic [thermal_pkg::TAU_W-1:0] tau_wind_min,
  input  wire logic [thermal_pkg::TAU_W-1:0] tau_oil_min,
  // state clear requests
  input  wire logic                         reset_input,
  input  wire logic                         reset_menu,
  // results
  output logic [thermal_pkg::OUT_W-1:0]     thermal_state,
  output logic                              alarm,
  output logic                              trip,
  output logic                              update_done
);
  import thermal_pkg::*;

  function automatic logic [SET_W-1:0] clamp(input logic [SET_W-1:0] v,
                                             input logic [SET_W-1:0] lo,
                                             input logic [SET_W-1:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic rst_meta_n_r, rst_n_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n_r <= 1'b0;
      rst_n_r      <= 1'b0;
    end else begin
      rst_meta_n_r <= 1'b1;
      rst_n_r      <= rst_meta_n_r;
    end
  end

  div_if #(.NW(NUM_W), .DW(DEN_W)) dv ();
  thermal_div #(.NW(NUM_W), .DW(DEN_W)) u_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_r),
    .d       (dv.srv)
  );

  // settings out of range are pulled to the nearest legal value
  logic [SET_W-1:0] fls_c, alarm_c, tau1_c, tau2_c;
  assign fls_c   = clamp(full_load_setting, FLS_MIN, FLS_MAX);          // RULE_09
  assign alarm_c = clamp({2'h0, alarm_pct}, ALARM_MIN, ALARM_MAX);      // RULE_09
  assign tau1_c  = clamp({1'h0, tau_wind_min}, TAU_MIN, TAU_MAX);       // RULE_09
  assign tau2_c  = clamp({1'h0, tau_oil_min}, TAU_MIN, TAU_MAX);        // RULE_09

  logic enabled, dual, clear_req;
  assign enabled   = (char_mode == MODE_SINGLE) || (char_mode == MODE_DUAL);
  assign dual      = (char_mode == MODE_DUAL);
  assign clear_req = reset_input || reset_menu;

  logic [CUR_W-1:0] imax;
  always_comb begin
    imax = phase_a;                                                       // RULE_01
    if (phase_b > imax) imax = phase_b;                                   // RULE_01
    if (phase_c > imax) imax = phase_c;                                   // RULE_01
  end

  seq_t             st_r, st_nxt;
  logic [31:0]      tick_cnt_r, tick_cnt_nxt;
  logic [CUR_W-1:0] imax_r, imax_nxt;
  logic [TH_W-1:0]  target_r, target_nxt, step1_r, step1_nxt, step2_r, step2_nxt;
  logic [TH_W-1:0]  th1_r, th1_nxt, th2_r, th2_nxt;
  logic             issued_r, issued_nxt, done_r, done_nxt, tick;

  // squared terms; no temperature input exists, only current drives the model
  logic [2*CUR_W-1:0] i_sq;
  logic [32:0]        i_sq_k;
  logic [17:0]        fls_sq;
  logic [26:0]        den_tgt;
  logic [20:0]        den_t1, den_t2;
  logic [TH_W-1:0]    diff1, diff2, quo_sat;
  logic               up1, up2;
  assign i_sq    = imax_r * imax_r;                                       // RULE_08
  assign i_sq_k  = 33'(i_sq) * 33'(K_SQ_NUM);                            // RULE_03
  assign fls_sq  = fls_c * fls_c;
  assign den_tgt = 27'(fls_sq) * 27'(K_SQ_DEN);                          // RULE_03
  assign den_t1  = 21'(tau1_c) * 21'(STEPS_PER_MIN);
  assign den_t2  = 21'(tau2_c) * 21'(STEPS_PER_MIN);
  assign up1     = target_r >= th1_r;
  assign up2     = target_r >= th2_r;
  assign diff1   = up1 ? target_r - th1_r : th1_r - target_r;
  assign diff2   = up2 ? target_r - th2_r : th2_r - target_r;
  assign quo_sat = (|dv.quo[NUM_W-1:TH_W]) ? {TH_W{1'b1}} : dv.quo[TH_W-1:0];
  assign tick    = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));

  always_comb begin
    st_nxt       = st_r;
    tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
    imax_nxt     = imax_r;
    target_nxt   = target_r;
    step1_nxt    = step1_r;
    step2_nxt    = step2_r;
    th1_nxt      = th1_r;
    th2_nxt      = th2_r;
    issued_nxt   = issued_r;
    done_nxt     = 1'b0;
    dv.start     = 1'b0;
    dv.num       = '0;
    dv.den       = '0;
    case (st_r)
      S_IDLE: begin
        if (tick && enabled) begin
          imax_nxt = imax;                                                // RULE_01
          st_nxt   = S_TGT;
        end
      end
      S_TGT: begin
        dv.num = {3'h0, i_sq_k, 16'h0};                                   // RULE_02
        dv.den = {5'h0, den_tgt};                                         // RULE_02
      end
      S_WIND: begin
        dv.num = {12'h0, diff1};                                          // RULE_13
        dv.den = {11'h0, den_t1};                                         // RULE_07
      end
      S_OIL: begin
        dv.num = {12'h0, diff2};                                          // RULE_13
        dv.den = {11'h0, den_t2};                                         // RULE_07
      end
      S_UPD: begin
        // a step of at least one lsb keeps a tiny gap from stalling forever
        if (diff1 != '0) begin
          th1_nxt = up1 ? th1_r + ((step1_r == '0) ? 40'h1 : step1_r)
                        : th1_r - ((step1_r == '0) ? 40'h1 : step1_r);  // RULE_05
        end
        if (dual && diff2 != '0) begin
          th2_nxt = up2 ? th2_r + ((step2_r == '0) ? 40'h1 : step2_r)
                        : th2_r - ((step2_r == '0) ? 40'h1 : step2_r);  // RULE_06
        end
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
    if (st_r == S_TGT || st_r == S_WIND || st_r == S_OIL) begin
      if (!issued_r && !dv.busy) begin
        dv.start   = 1'b1;
        issued_nxt = 1'b1;
      end else if (dv.done) begin
        issued_nxt = 1'b0;
        case (st_r)
          S_TGT:   begin target_nxt = quo_sat; st_nxt = S_WIND; end        // RULE_02
          S_WIND:  begin step1_nxt = quo_sat; st_nxt = dual ? S_OIL : S_UPD; end
          default: begin step2_nxt = quo_sat; st_nxt = S_UPD; end
        endcase
      end
    end
    if (!dual) th2_nxt = '0;
    if (clear_req || !enabled) begin                                      // RULE_11
      th1_nxt = '0;                                                       // RULE_11
      th2_nxt = '0;                                                       // RULE_13
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r       <= S_IDLE;
      tick_cnt_r <= 32'h0;
      imax_r     <= '0;
      target_r   <= '0;
      step1_r    <= '0;
      step2_r    <= '0;
      th1_r      <= '0;
      th2_r      <= '0;
      issued_r   <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      imax_r     <= imax_nxt;
      target_r   <= target_nxt;
      step1_r    <= step1_nxt;
      step2_r    <= step2_nxt;
      th1_r      <= th1_nxt;
      th2_r      <= th2_nxt;
      issued_r   <= issued_nxt;
      done_r     <= done_nxt;
    end
  end

  // combined state and the output stage
  logic [57:0]      mix;
  logic [TH_W-1:0]  theta;
  logic [46:0]      theta_pct;
  logic [OUT_W-1:0] disp_nxt, disp_r;
  logic             alarm_nxt, alarm_r, trip_nxt, trip_r;
  assign mix       = 58'(th1_r) * 58'(W_WINDING) + 58'(th2_r) * 58'(W_OIL);   // RULE_06
  assign theta     = dual ? mix[FRAC +: TH_W] : th1_r;                    // RULE_06
  assign theta_pct = 47'(theta) * 47'(PCT_SCALE);

  always_comb begin
    disp_nxt  = (|theta[TH_W-1:OUT_W]) ? {OUT_W{1'b1}} : theta[OUT_W-1:0]; // RULE_10
    trip_nxt  = enabled && (theta >= THETA_ONE);                          // RULE_04
    alarm_nxt = enabled && (theta_pct >= {22'h0, alarm_c, 16'h0});       // RULE_12
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      disp_r  <= '0;
      alarm_r <= 1'b0;
      trip_r  <= 1'b0;
    end else begin
      disp_r  <= disp_nxt;
      alarm_r <= alarm_nxt;
      trip_r  <= trip_nxt;
    end
  end

  assign thermal_state = disp_r;
  assign alarm         = alarm_r;
  assign trip          = trip_r;
  assign update_done   = done_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  max_phase_a: assert property (st_r == S_IDLE && tick && enabled |=>  // RULE_01
    imax_r >= $past(phase_a) && imax_r >= $past(phase_b) && imax_r >= $past(phase_c))
    else $error("model input is not the largest phase");
  trip_level_a: assert property (enabled && theta >= THETA_ONE |=> trip) // RULE_04
    else $error("trip missing at full thermal state");
  trip_below_a: assert property (theta < THETA_ONE |=> !trip)         // RULE_04
    else $error("trip raised below full thermal state");
  heat_dir_a: assert property (st_r == S_UPD && up1 && !clear_req && enabled // RULE_05
    |=> th1_r >= $past(th1_r) && th1_r <= $past(target_r))
    else $error("heating step moved away from target");
  single_oil_a: assert property (char_mode == MODE_SINGLE |=> th2_r == '0) // RULE_06
    else $error("oil part active in single mode");
  clear_zero_a: assert property (clear_req |=> th1_r == '0 && th2_r == '0) // RULE_11
    else $error("thermal state not cleared");
  off_quiet_a: assert property (!enabled ##1 !enabled |=> !trip && !alarm) // RULE_13
    else $error("outputs active while disabled");
  alarm_pct_a: assert property (enabled && theta_pct >= {22'h0, alarm_c, 16'h0} // RULE_12
    |=> alarm)
    else $error("alarm missing at its level");
  display_a: assert property (theta < 40'h01_0000_0000 // RULE_10
    |=> thermal_state == $past(theta[31:0]))
    else $error("display does not follow state");
  update_span_a: assert property (st_r == S_IDLE && tick && enabled // RULE_13
    |-> ##[3:200] update_done)
    else $error("update did not complete");

  cov_trip_c:  cover property (!trip ##1 trip);
  cov_alarm_c: cover property (!alarm ##1 alarm);
  cov_dual_c:  cover property (dual && update_done);
  cov_clear_c: cover property (trip && clear_req);
endmodule
`default_nettype wire

/* testbench/thermal_feed_model.sv */
// far-side model: phase measurement feed and scheme-logic clear input
`default_nettype none
module thermal_feed_model (
  // clock
  input  wire logic                         ref_clk,
  // commands from the bench
  input  wire logic [thermal_pkg::CUR_W-1:0] level,
  input  wire logic                         clr_req,
  // toward the replica
  output logic [thermal_pkg::CUR_W-1:0]     phase_a,
  output logic [thermal_pkg::CUR_W-1:0]     phase_b,
  output logic [thermal_pkg::CUR_W-1:0]     phase_c,
  output logic                              reset_input
);
  timeunit 1ns;
  timeprecision 1ps;
  import thermal_pkg::*;
  logic [1:0] rot_r;
  initial begin
    rot_r = 2'h0;
    phase_a = '0;
    phase_b = '0;
    phase_c = '0;
    reset_input = 1'b0;
  end
  // the largest magnitude hops to another phase every edge, so a replica
  // that watched one fixed phase would see the smaller values at its tick
  always @(posedge ref_clk) begin
    rot_r <= (rot_r == 2'h2) ? 2'h0 : rot_r + 2'h1;
    phase_a <= (rot_r == 2'h0) ? level : level >> 1;
    phase_b <= (rot_r == 2'h1) ? level : level >> 2;
    phase_c <= (rot_r == 2'h2) ? level : level >> 1;
    // opto input assigned to the clear function passes through scheme logic
    reset_input <= clr_req;
  end
endmodule
`default_nettype wire

/* testbench/thermal_overload_tb_top.sv */
// self-checking bench of the thermal replica
`default_nettype none
module thermal_overload_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import thermal_pkg::*;
  localparam int SC   = 300;
  localparam int CEIL = 20000;
  logic             ref_clk = 1'b0;
  logic             rstn = 1'b0;
  logic [CUR_W-1:0] level = '0;
  logic             clr_req = 1'b0;
  logic             reset_menu = 1'b0;
  mode_t            char_mode = MODE_OFF;
  logic [SET_W-1:0] fls = 9'h008;
  logic [PCT_W-1:0] apct = 7'h46;
  logic [TAU_W-1:0] tw = 8'h01;
  logic [TAU_W-1:0] to = 8'h01;
  logic [CUR_W-1:0] pa, pb, pc;
  logic             rin;
  logic [OUT_W-1:0] thermal_state;
  logic             alarm, trip, update_done;
  int               num_errors = 0;
  int               samples_checked = 0;
  int               cyc = 0;
  int               cold, hot, n;
  logic [63:0]      th1 = '0;
  logic [63:0]      th2 = '0;

  always #2 ref_clk = ~ref_clk;

  thermal_feed_model u_feed (.ref_clk(ref_clk), .level(level), .clr_req(clr_req),
    .phase_a(pa), .phase_b(pb), .phase_c(pc), .reset_input(rin));

  thermal_overload #(.SAMPLE_CYCLES(SC)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .phase_a(pa), .phase_b(pb), .phase_c(pc), .char_mode(char_mode),
    .full_load_setting(fls), .alarm_pct(apct), .tau_wind_min(tw), .tau_oil_min(to),
    .reset_input(rin), .reset_menu(reset_menu), .thermal_state(thermal_state),
    .alarm(alarm), .trip(trip), .update_done(update_done));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      num_errors++;
      end_of_test();
    end
  end

  function automatic logic [63:0] clampv(input logic [63:0] v, lo, hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // one exponential step; at least one lsb so the state never sticks short of target
  function automatic logic [63:0] stepv(input logic [63:0] th, tg, tau);
    logic [63:0] d, s;
    d = (tg > th) ? tg - th : th - tg;
    s = d / (tau * STEPS_PER_MIN);
    if (s == 0 && d != 0) s = 1;
    return (tg > th) ? th + s : th - s;
  endfunction

  // the divider and weighting may round differently by a lsb or two
  function automatic bit near(input logic [63:0] st);
    return (thermal_state !== 'x) && ({32'h0, thermal_state} + 64'd2 >= st)
      && ({32'h0, thermal_state} <= st + 64'd2);
  endfunction

  task automatic upd(input bit dual);
    logic [63:0] f, i, tg, st, a;
    int w;
    w = 0;
    do begin
      @(posedge ref_clk);
      w++;
    end while (update_done !== 1'b1 && w < 700);
    // inputs are read after the update, as a nonblocking change made just before the
    // call has not landed yet at call time
    f = clampv(fls, 8, 320);
    i = level;
    tg = i * i * 400 * 65536 / (441 * f * f);
    if (tg > 64'hFF_FFFF_FFFF) tg = 64'hFF_FFFF_FFFF;
    th1 = stepv(th1, tg, clampv(tw, 1, 200));
    th2 = dual ? stepv(th2, tg, clampv(to, 1, 200)) : 64'h0;
    st = dual ? (th1 * 64'h6666 + th2 * 64'h999A) >> 16 : th1;
    if (st > 64'hFFFF_FFFF) st = 64'hFFFF_FFFF;
    a = clampv(apct, 50, 100);
    // the output registers take the new state one edge after the done pulse
    @(negedge ref_clk);
    chk(w < 700, 1);
    chk(near(st), 1);
    chk(trip, st >= 65536);
    chk(alarm, st * 100 >= a * 65536);
    repeat (40) @(posedge ref_clk);
    chk(near(st), 1);
  endtask

  task automatic clear(input bit menu);
    @(posedge ref_clk);
    if (menu) reset_menu <= 1'b1;
    else clr_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(thermal_state, 0);
    reset_menu <= 1'b0;
    clr_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({alarm, trip}, 0);
    th1 = '0;
    th2 = '0;
  endtask

  task automatic run_to_trip(output int cnt);
    cnt = 0;
    do begin
      upd(1'b0);
      cnt++;
    end while (trip !== 1'b1 && cnt < 12);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    chk({thermal_state, alarm, trip, update_done}, 0);
    rstn <= 1'b1;
    level <= 12'hFFF;
    // disabled and the unused code 3 must both stay silent under heavy current
    n = 0;
    for (int c = 0; c < 4 * SC; c++) begin
      @(posedge ref_clk);
      if (c == 2 * SC) char_mode <= mode_t'(2'h3);
      if (update_done === 1'b1 || trip === 1'b1 || alarm === 1'b1) n++;
    end
    chk(n, 0);
    chk(thermal_state, 0);
    // cold start, overload of 300 against a setting of 8
    level <= 12'h12C;
    char_mode <= MODE_SINGLE;
    run_to_trip(cold);
    clear(1'b1);
    // one tick at a heavier load preloads the plant before the same overload
    level <= 12'h168;
    upd(1'b0);
    level <= 12'h12C;
    run_to_trip(hot);
    chk(hot < cold, 1);
    clear(1'b0);
    // dual, with settings outside their ranges to be clamped
    fls <= 9'h000;
    tw <= 8'h00;
    to <= 8'h02;
    apct <= 7'h1E;
    char_mode <= MODE_DUAL;
    repeat (3) upd(1'b1);
    apct <= 7'h78;
    repeat (3) upd(1'b1);
    char_mode <= MODE_OFF;
    repeat (5) @(posedge ref_clk);
    chk({thermal_state, alarm, trip}, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
